// >>> bench/testbench.sv
// self-checking bench for one enhanced flow control channel
`timescale 1ns/1ns
module testbench
   import ueflow_pkg::*;
;
   logic        clk, reset_n, psel, penable, pwrite, tx_req, tx_bit, cts_n, dsr_n, slow, pready, pslverr, err;
   logic        tx_busy;
   logic        rx_valid, tx_start, sout, fl_valid, fl_ready, rts_n, dtr_n, rx_dma_n, tx_dma_n, irq;
   logic [7:0]  paddr, rx_data, fl_data;
   logic [31:0] pwdata, prdata, rd;
   int          mismatches, checks, cycles;
   integer      seed;
   logic [7:0]  sent [$];

   ueflow_top ueflow_top_inst (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx_valid),
      .RX_DATA(rx_data), .TX_REQ(tx_req), .TX_BUSY(tx_busy), .TX_START(tx_start), .TX_BIT(tx_bit), .SOUT(sout),
      .TX_FLOW_VALID(fl_valid), .TX_FLOW_DATA(fl_data), .TX_FLOW_READY(fl_ready), .CTS_N(cts_n), .DSR_N(dsr_n),
      .RI_N(1'b1), .CD_N(1'b1), .RTS_N(rts_n), .DTR_N(dtr_n), .RECEIVE_DMA_REQUEST_N(rx_dma_n),
      .TRANSMIT_DMA_REQUEST_N(tx_dma_n), .RX_TRIGGER_IRQ(irq));
   ueflow_peer ueflow_peer_inst (.clk(clk), .rst_n(reset_n), .slow(slow), .flow_valid(fl_valid),
      .flow_data(fl_data), .flow_ready(fl_ready), .rx_valid(rx_valid), .rx_data(rx_data));

   always #5 clk = ~clk;

   function automatic logic [15:0] pair_of(input logic [1:0] sel, input logic [7:0] c1, input logic [7:0] c2);
      pair_of = (sel == 2'b10) ? {8'h00, c1} : (sel == 2'b01) ? {8'h00, c2} : {c1, c2};
   endfunction : pair_of

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, rd, err);
   endtask : reg_wr

   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, {24'h0, exp});
   endtask : reg_chk

   task automatic push_rand();
      logic [7:0] c;
      c = 8'($random(seed)) & 8'h7f;
      sent.push_back(c);
      ueflow_peer_inst.send(c);
   endtask : push_rand

   task automatic pop_chk();
      reg_chk(OFS_RX_DATA, sent.pop_front());
   endtask : pop_chk

   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic see_start(input logic exp);
      settle();
      chk({31'h0, tx_start}, {31'h0, exp});
   endtask : see_start

   task automatic send_seq(input logic [1:0] sel, input logic [7:0] c1, input logic [7:0] c2);
      if (sel[1])
         ueflow_peer_inst.send(c1);
      if (sel[0])
         ueflow_peer_inst.send(c2);
   endtask : send_seq

   task automatic wait_flow(input int n);
      for (int i = 0; i < 300 && ueflow_peer_inst.got.size() < n; i++)
         @(posedge clk);
   endtask : wait_flow

   // a hang counts as a mismatch
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         mismatches = mismatches + 1;
         give_verdict();
      end
   end

   initial
   begin
      clk = 1'b0;
      reset_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, tx_req, tx_busy, dsr_n, slow} = '0;
      {tx_bit, cts_n} = 2'b11;
      {mismatches, checks, cycles} = '0;
      seed = 32'h5f2159fe;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({27'h0, sout, rts_n, dtr_n, rx_dma_n, tx_dma_n}, 32'h1e);
      @(posedge clk);
      reset_n <= 1'b1;
      settle();
      chk({27'h0, sout, rts_n, dtr_n, rx_dma_n, tx_dma_n}, 32'h1e);
      reg_chk(OFS_IER, 8'h00);
      reg_chk(OFS_LCR, 8'h00);
      reg_chk(OFS_MCR, 8'h00);
      reg_chk(OFS_FCR, 8'h00);
      reg_chk(OFS_EFR, 8'h00);
      reg_chk(OFS_ISR, 8'h01);
      reg_chk(OFS_LSR, 8'h60);
      reg_chk(OFS_MSR, 8'h20);
      apb(1'b0, 8'h34, 32'h0, rd, err);
      chk({err, rd[30:0]}, 32'h80000000);
      reg_wr(OFS_IER, 8'hff);
      reg_chk(OFS_IER, 8'h0f);
      reg_wr(OFS_MCR, 8'he3);
      reg_chk(OFS_MCR, 8'h03);
      reg_wr(OFS_EFR, 8'h10);
      reg_wr(OFS_IER, 8'hff);
      reg_chk(OFS_IER, 8'hff);
      reg_wr(OFS_EFR, 8'h00);
      reg_wr(OFS_IER, 8'h01);
      reg_chk(OFS_IER, 8'hf1);
      settle();
      chk({30'h0, rts_n, dtr_n}, 32'h0);
      tx_req <= 1'b1;
      reg_wr(OFS_EFR, 8'h80);
      see_start(1'b0);
      @(posedge clk);
      cts_n <= 1'b0;
      see_start(1'b1);
      // no start while a character shifts
      @(posedge clk);
      tx_busy <= 1'b1;
      tx_bit  <= 1'b0;
      settle();
      chk({29'h0, tx_start, tx_dma_n, sout}, 32'h2);
      @(posedge clk);
      tx_busy <= 1'b0;
      tx_bit  <= 1'b1;
      reg_wr(OFS_EFR, 8'h40);
      reg_wr(OFS_MCR, 8'h02);
      repeat (15) push_rand();
      settle();
      chk({29'h0, irq, rts_n, rx_dma_n}, 32'h4);
      reg_chk(OFS_ISR, 8'h04);
      push_rand();
      settle();
      chk({31'h0, rts_n}, 32'h1);
      repeat (15) pop_chk();
      settle();
      chk({31'h0, rts_n}, 32'h1);
      pop_chk();
      settle();
      chk({31'h0, rts_n}, 32'h0);
      reg_wr(OFS_EFR, 8'h00);
      reg_wr(OFS_MCR, 8'h01);
      settle();
      chk({30'h0, rts_n, dtr_n}, 32'h2);
      reg_wr(OFS_PAUSE2, 8'h96);
      reg_wr(OFS_EFR, 8'h20);
      ueflow_peer_inst.send(8'h69);
      settle();
      reg_chk(OFS_ISR, 8'h01);
      ueflow_peer_inst.send(8'h96);
      settle();
      reg_chk(OFS_ISR, 8'h10);
      reg_chk(OFS_ISR, 8'h01);
      reg_chk(OFS_RX_DATA, 8'h69);
      reg_chk(OFS_RX_DATA, 8'h96);
      reg_wr(OFS_RESUME1, 8'h91);
      reg_wr(OFS_RESUME2, 8'h93);
      reg_wr(OFS_PAUSE1, 8'h81);
      reg_wr(OFS_PAUSE2, 8'h83);
      for (int m = 1; m < 4; m++)
      begin
         reg_wr(OFS_EFR, {4'h0, 2'(m), 2'b00});
         slow <= m[0];
         repeat (8) push_rand();
         wait_flow(m == 3 ? 2 : 1);
         chk({16'h0, ueflow_peer_inst.take()}, {16'h0, pair_of(2'(m), 8'h81, 8'h83)});
         repeat (8) pop_chk();
         wait_flow(m == 3 ? 2 : 1);
         chk({16'h0, ueflow_peer_inst.take()}, {16'h0, pair_of(2'(m), 8'h91, 8'h93)});
      end
      for (int m = 1; m < 4; m++)
      begin
         reg_wr(OFS_EFR, {6'h0, 2'(m)});
         ueflow_peer_inst.send(m == 1 ? 8'h81 : 8'h83);
         see_start(1'b1);
         send_seq(2'(m), 8'h81, 8'h83);
         see_start(1'b0);
         send_seq(2'(m), 8'h91, 8'h93);
         see_start(1'b1);
         repeat (m == 3 ? 5 : 3) apb(1'b0, OFS_RX_DATA, 32'h0, rd, err);
      end
      give_verdict();
   end
endmodule : testbench

// >>> bench/ueflow_peer.sv
// far-side serial peer: sends received characters, accepts flow characters
`timescale 1ns/1ns
module ueflow_peer
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       slow,
   input  wire logic       flow_valid,
   input  wire logic [7:0] flow_data,
   output logic            flow_ready,
   output logic            rx_valid,
   output logic      [7:0] rx_data
);
   logic [7:0] got [$];
   logic [1:0] pace_q;

   initial
   begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
   end

   task automatic send(input logic [7:0] c);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= c;
      @(posedge clk);
      rx_valid <= 1'b0;
      // idle line shows the inverse so a stale byte never looks valid
      rx_data  <= ~c;
   endtask : send

   function automatic logic [15:0] take();
      take = (got.size() == 2) ? {got[0], got[1]} : (got.size() == 1) ? {8'h00, got[0]} : 16'hffff;
      got.delete();
   endfunction : take

   // a slow peer accepts only every fourth cycle
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         pace_q     <= 2'h0;
         flow_ready <= 1'b0;
      end
      else
      begin
         pace_q     <= pace_q + 2'h1;
         flow_ready <= flow_valid && !flow_ready && (!slow || pace_q == 2'h3);
         if (flow_valid && flow_ready)
            got.push_back(flow_data);
      end
endmodule : ueflow_peer

// >>> common/ueflow_fifo_if.sv
// signals between the channel logic and its receive store
`timescale 1ns/1ns
interface ueflow_fifo_if;
   logic       push;
   logic [7:0] push_data;
   logic       pop;
   logic [7:0] rd_data;
   logic [6:0] level;
   logic       empty;
   logic       full;
   modport owner (output push, push_data, pop, input rd_data, level, empty, full);
   modport store (input push, push_data, pop, output rd_data, level, empty, full);
endinterface : ueflow_fifo_if

// >>> common/ueflow_pkg.sv
// constants, types and helpers shared by the enhanced flow control channel
package ueflow_pkg;

   localparam int DATA_W     = 8;
   localparam int PTR_W      = 6;
   localparam int LVL_W      = 7;
   localparam int FIFO_DEPTH = 64;

   localparam logic [7:0] OFS_RX_DATA = 8'h00;
   localparam logic [7:0] OFS_IER     = 8'h04;
   localparam logic [7:0] OFS_ISR     = 8'h08;
   localparam logic [7:0] OFS_FCR     = 8'h0c;
   localparam logic [7:0] OFS_LCR     = 8'h10;
   localparam logic [7:0] OFS_MCR     = 8'h14;
   localparam logic [7:0] OFS_LSR     = 8'h18;
   localparam logic [7:0] OFS_MSR     = 8'h1c;
   localparam logic [7:0] OFS_EFR     = 8'h20;
   localparam logic [7:0] OFS_RESUME1 = 8'h24;
   localparam logic [7:0] OFS_RESUME2 = 8'h28;
   localparam logic [7:0] OFS_PAUSE1  = 8'h2c;
   localparam logic [7:0] OFS_PAUSE2  = 8'h30;

   localparam logic [7:0] RST_IER  = 8'h00;
   localparam logic [7:0] RST_ISR  = 8'h01;
   localparam logic [7:0] RST_LCR  = 8'h00;
   localparam logic [7:0] RST_MCR  = 8'h00;
   localparam logic [7:0] RST_LSR  = 8'h60;
   localparam logic [7:0] RST_FCR  = 8'h00;
   localparam logic [7:0] RST_EFR  = 8'h00;
   localparam logic [7:0] RST_CHAR = 8'h00;

   localparam int EFR_AUTO_CTS  = 7;
   localparam int EFR_AUTO_RTS  = 6;
   localparam int EFR_SPECIAL   = 5;
   localparam int EFR_ENH       = 4;
   localparam int ISR_NONE      = 0;
   localparam int ISR_RX_TRIG   = 2;
   localparam int ISR_SPECIAL   = 4;
   localparam int IER_RX_TRIG   = 0;
   localparam int MCR_DTR       = 0;
   localparam int MCR_RTS       = 1;
   localparam int LSR_DATA_RDY  = 0;
   localparam int LSR_HOLD_EMPT = 5;
   localparam int LSR_TX_EMPTY  = 6;

   localparam logic [7:0] IER_ENH_MASK = 8'hf0;
   localparam logic [7:0] FCR_ENH_MASK = 8'h30;
   localparam logic [7:0] MCR_ENH_MASK = 8'he0;

   localparam logic [LVL_W-1:0] TRIG_L0 = 7'h08;
   localparam logic [LVL_W-1:0] TRIG_L1 = 7'h10;
   localparam logic [LVL_W-1:0] TRIG_L2 = 7'h38;
   localparam logic [LVL_W-1:0] TRIG_L3 = 7'h3c;
   localparam logic [LVL_W-1:0] LVL_FULL = 7'h40;
   localparam logic [LVL_W-1:0] LVL_ONE  = 7'h01;

   localparam logic [1:0] SEL_NONE   = 2'b00;
   localparam logic [1:0] SEL_FIRST  = 2'b10;
   localparam logic [1:0] SEL_SECOND = 2'b01;
   localparam logic [1:0] SEL_BOTH   = 2'b11;

   typedef enum logic [1:0] {FL_IDLE = 2'b00, FL_FIRST = 2'b01, FL_SECOND = 2'b11} ueflow_tx_e;

   function automatic logic [LVL_W-1:0] ueflow_trig(input logic [1:0] idx);
      ueflow_trig = (idx == 2'h0) ? TRIG_L0 : (idx == 2'h1) ? TRIG_L1 : (idx == 2'h2) ? TRIG_L2 : TRIG_L3;
   endfunction : ueflow_trig

endpackage : ueflow_pkg

// >>> src/ueflow_rx_store.sv
// receive character store with registered read data
`timescale 1ns/1ns
module ueflow_rx_store
   import ueflow_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  reset_n,
   ueflow_fifo_if.store f
);
   logic [DATA_W-1:0] mem [FIFO_DEPTH];
   logic [PTR_W:0]    wr_q;
   logic [PTR_W:0]    rd_q;
   logic [DATA_W-1:0] rd_data_q;
   wire               do_push = f.push & ~f.full;
   wire               do_pop  = f.pop & ~f.empty;
   wire [PTR_W:0]     wr_d    = do_push ? wr_q + 1'b1 : wr_q;
   wire [PTR_W:0]     rd_d    = do_pop ? rd_q + 1'b1 : rd_q;
   // bypass keeps the head byte fresh when it is written into an empty slot
   wire               bypass  = do_push & (wr_q[PTR_W-1:0] == rd_d[PTR_W-1:0]);

   assign f.level   = wr_q - rd_q;
   assign f.empty   = (wr_q == rd_q);
   assign f.full    = (f.level == LVL_FULL);
   assign f.rd_data = rd_data_q;

   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[wr_q[PTR_W-1:0]] <= f.push_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_q      <= '0;
         rd_q      <= '0;
         rd_data_q <= RST_CHAR;
      end
      else
      begin
         wr_q      <= wr_d;
         rd_q      <= rd_d;
         rd_data_q <= bypass ? f.push_data : mem[rd_d[PTR_W-1:0]];
      end
   end
endmodule : ueflow_rx_store

// >>> src/ueflow_top.sv
// one channel of enhanced flow control with its apb register file
`timescale 1ns/1ns
// Function
// - auto cts stops transmit while pin high
// - character in progress finishes before stopping
// - auto rts raises rts at the next trigger level up
// - rts returns low below lower trigger
// - without auto rts, rts follows modem control
// - special character sets status, still stored
// - special detect compares whole byte with pause two
// - enhanced bits writable only while enabled
// - upper selection bits pick transmit characters
// - lower selection bits pick receive comparison
// - both lower bits compare two-character sequences
// - dual mode sends and matches character pairs
// - reset clears control and feature registers
// - reset shows no interrupt pending
// - reset line status reads transmitter empty
// - reset modem status mirrors pins, deltas clear
// - reset drives serial, rts, dtr outputs high
module ueflow_top
   import ueflow_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        RX_VALID,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        TX_REQ,
   input  wire logic        TX_BUSY,
   output logic             TX_START,
   input  wire logic        TX_BIT,
   output logic             SOUT,
   output logic             TX_FLOW_VALID,
   output logic      [7:0]  TX_FLOW_DATA,
   input  wire logic        TX_FLOW_READY,
   input  wire logic        CTS_N,
   input  wire logic        DSR_N,
   input  wire logic        RI_N,
   input  wire logic        CD_N,
   output logic             RTS_N,
   output logic             DTR_N,
   output logic             RECEIVE_DMA_REQUEST_N,
   output logic             TRANSMIT_DMA_REQUEST_N,
   output logic             RX_TRIGGER_IRQ
);
   ueflow_fifo_if fifo ();

   logic [7:0] ier_q, isr_q, fcr_q, lcr_q, mcr_q, lsr_q, efr_q;
   logic [7:0] resume1_q, resume2_q, pause1_q, pause2_q;
   logic [3:0] pin_meta_q, pin_sync_q, pin_prev_q, delta_q;
   // deltas stay masked until the synchroniser holds real pin values
   logic [2:0] prime_q;
   logic [31:0] prdata_q;
   logic       rts_hold_q, remote_pause_q, prev_p1_q, prev_r1_q, pause_sent_q, kind_q;
   logic       sout_q, rts_n_q, dtr_n_q, rx_dma_n_q, tx_dma_n_q;
   logic [7:0] flow_data_q;
   ueflow_tx_e fl_q, fl_d;
   logic       kind_d, pause_sent_d;
   logic [7:0] flow_data_d;

   function automatic logic [7:0] guard(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] mask, input logic enh);
      guard = enh ? new_v : ((old_v & mask) | (new_v & ~mask));
   endfunction : guard

   function automatic logic pick(input logic [1:0] sel, input logic a, input logic b, input logic seq);
      pick = (sel == SEL_FIRST) ? a : (sel == SEL_SECOND) ? b : (sel == SEL_BOTH) ? seq : 1'b0;
   endfunction : pick

   // apb decode
   wire       apb_setup = PSEL & ~PENABLE;
   wire       apb_wr    = PSEL & PENABLE & PWRITE;
   wire       apb_rd    = PSEL & PENABLE & ~PWRITE;
   wire [7:0] wdat      = PWDATA[7:0];
   wire       mapped    = (PADDR[1:0] == 2'b00) && (PADDR <= OFS_PAUSE2);
   wire       enh       = efr_q[EFR_ENH];
   wire [7:0] rd_mux    = (PADDR == OFS_RX_DATA) ? fifo.rd_data :
                          (PADDR == OFS_IER)     ? ier_q :
                          (PADDR == OFS_ISR)     ? isr_q :
                          (PADDR == OFS_FCR)     ? fcr_q :
                          (PADDR == OFS_LCR)     ? lcr_q :
                          (PADDR == OFS_MCR)     ? mcr_q :
                          (PADDR == OFS_LSR)     ? lsr_q :
                          (PADDR == OFS_MSR)     ? {~pin_sync_q, delta_q} :
                          (PADDR == OFS_EFR)     ? efr_q :
                          (PADDR == OFS_RESUME1) ? resume1_q :
                          (PADDR == OFS_RESUME2) ? resume2_q :
                          (PADDR == OFS_PAUSE1)  ? pause1_q :
                          (PADDR == OFS_PAUSE2)  ? pause2_q : 8'h00;

   assign PRDATA  = prdata_q;
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;

   wire isr_read = apb_rd & (PADDR == OFS_ISR);
   wire msr_read = apb_rd & (PADDR == OFS_MSR);

   // fifo levels and triggers
   wire [1:0]       trig_idx = fcr_q[7:6];
   wire [LVL_W-1:0] level    = fifo.level;
   wire [LVL_W-1:0] trig_lvl = ueflow_trig(trig_idx);
   wire [LVL_W-1:0] hi_lvl   = (trig_idx == 2'h3) ? LVL_FULL : ueflow_trig(trig_idx + 2'h1);
   wire [LVL_W-1:0] lo_lvl   = (trig_idx == 2'h0) ? LVL_ONE : ueflow_trig(trig_idx - 2'h1);
   wire             at_trig  = (level >= trig_lvl);

   assign fifo.push      = RX_VALID;
   assign fifo.push_data = RX_DATA;
   assign fifo.pop       = apb_rd & (PADDR == OFS_RX_DATA);

   ueflow_rx_store u_store (
      .clk     (CLK),
      .reset_n (RESET_N),
      .f       (fifo.store)
   );

   // modem pin synchronisers and change detection
   wire [3:0] modem_pins = {CD_N, RI_N, DSR_N, CTS_N};
   wire [3:0] delta_set;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_delta
         if (g == 2)
         begin : g_ri
            // ring indicator only flags the trailing edge of the ring
            assign delta_set[g] = ~pin_prev_q[g] & pin_sync_q[g];
         end
         else
         begin : g_chg
            assign delta_set[g] = pin_prev_q[g] ^ pin_sync_q[g];
         end
      end
   endgenerate

   wire m_p1 = (RX_DATA == pause1_q);
   wire m_p2 = (RX_DATA == pause2_q);
   wire m_r1 = (RX_DATA == resume1_q);
   wire m_r2 = (RX_DATA == resume2_q);
   wire [1:0] rx_sel = efr_q[1:0];
   wire [1:0] tx_sel = efr_q[3:2];
   wire pause_hit   = RX_VALID & pick(rx_sel, m_p1, m_p2, prev_p1_q & m_p2);
   wire resume_hit  = RX_VALID & pick(rx_sel, m_r1, m_r2, prev_r1_q & m_r2);
   wire special_hit = RX_VALID & efr_q[EFR_SPECIAL] & m_p2;

   wire tx_stop = (efr_q[EFR_AUTO_CTS] & pin_sync_q[0]) | remote_pause_q;
   assign TX_START = TX_REQ & ~TX_BUSY & ~tx_stop & (fl_q == FL_IDLE);

   // transmit flow characters
   wire need_pause  = (tx_sel != SEL_NONE) & ~pause_sent_q & at_trig;
   wire need_resume = pause_sent_q & (level < lo_lvl);
   assign TX_FLOW_VALID = (fl_q != FL_IDLE);
   assign TX_FLOW_DATA  = flow_data_q;

   always_comb
   begin
      fl_d         = fl_q;
      kind_d       = kind_q;
      pause_sent_d = pause_sent_q & (tx_sel != SEL_NONE);
      flow_data_d  = flow_data_q;
      case (fl_q)
         FL_IDLE:
         begin
            if (need_pause | need_resume)
            begin
               fl_d         = FL_FIRST;
               kind_d       = need_pause;
               pause_sent_d = need_pause;
               if (tx_sel == SEL_SECOND)
                  flow_data_d = need_pause ? pause2_q : resume2_q;
               else
                  flow_data_d = need_pause ? pause1_q : resume1_q;
            end
         end
         FL_FIRST:
         begin
            if (TX_FLOW_READY)
            begin
               if (tx_sel == SEL_BOTH)
               begin
                  fl_d        = FL_SECOND;
                  flow_data_d = kind_q ? pause2_q : resume2_q;
               end
               else
                  fl_d = FL_IDLE;
            end
         end
         FL_SECOND:
         begin
            if (TX_FLOW_READY)
               fl_d = FL_IDLE;
         end
         default:
            fl_d = FL_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ier_q <= RST_IER;
         isr_q <= RST_ISR;
         fcr_q <= RST_FCR;
         lcr_q <= RST_LCR;
         mcr_q <= RST_MCR;
         lsr_q <= RST_LSR;
         efr_q <= RST_EFR;
         resume1_q <= RST_CHAR;
         resume2_q <= RST_CHAR;
         pause1_q  <= RST_CHAR;
         pause2_q  <= RST_CHAR;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         if (apb_wr && PADDR == OFS_IER) ier_q <= guard(ier_q, wdat, IER_ENH_MASK, enh);
         if (apb_wr && PADDR == OFS_FCR) fcr_q <= guard(fcr_q, wdat, FCR_ENH_MASK, enh);
         if (apb_wr && PADDR == OFS_MCR) mcr_q <= guard(mcr_q, wdat, MCR_ENH_MASK, enh);
         if (apb_wr && PADDR == OFS_LCR) lcr_q <= wdat;
         if (apb_wr && PADDR == OFS_EFR) efr_q <= wdat;
         if (apb_wr && PADDR == OFS_RESUME1) resume1_q <= wdat;
         if (apb_wr && PADDR == OFS_RESUME2) resume2_q <= wdat;
         if (apb_wr && PADDR == OFS_PAUSE1) pause1_q <= wdat;
         if (apb_wr && PADDR == OFS_PAUSE2) pause2_q <= wdat;
         // status, set wins over read clear
         isr_q[ISR_SPECIAL] <= special_hit | (isr_q[ISR_SPECIAL] & ~isr_read);
         isr_q[ISR_RX_TRIG] <= at_trig & ier_q[IER_RX_TRIG];
         isr_q[ISR_NONE]    <= ~(isr_q[ISR_SPECIAL] | isr_q[ISR_RX_TRIG]);
         lsr_q <= {1'b0, ~(TX_BUSY | TX_REQ), ~(TX_BUSY | TX_REQ), 4'h0, ~fifo.empty};
         if (apb_setup) prdata_q <= {24'h00_0000, rd_mux};
      end
   end

   // pins synchronised, deltas cleared by reset
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pin_meta_q <= 4'hf;
         pin_sync_q <= 4'hf;
         pin_prev_q <= 4'hf;
         delta_q    <= 4'h0;
         prime_q    <= 3'h0;
      end
      else
      begin
         pin_meta_q <= modem_pins;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
         prime_q    <= {prime_q[1:0], 1'b1};
         delta_q    <= (delta_set & {4{prime_q[2]}}) | (delta_q & {4{~msr_read}});
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rts_hold_q     <= 1'b0;
         remote_pause_q <= 1'b0;
         prev_p1_q      <= 1'b0;
         prev_r1_q      <= 1'b0;
      end
      else
      begin
         if (!efr_q[EFR_AUTO_RTS]) rts_hold_q <= 1'b0;
         else if (level >= hi_lvl) rts_hold_q <= 1'b1;
         else if (level < lo_lvl)  rts_hold_q <= 1'b0;
         if (rx_sel == SEL_NONE) remote_pause_q <= 1'b0;
         else if (pause_hit)     remote_pause_q <= 1'b1;
         else if (resume_hit)    remote_pause_q <= 1'b0;
         if (RX_VALID)
         begin
            prev_p1_q <= m_p1;
            prev_r1_q <= m_r1;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         fl_q         <= FL_IDLE;
         kind_q       <= 1'b0;
         pause_sent_q <= 1'b0;
         flow_data_q  <= RST_CHAR;
      end
      else
      begin
         fl_q         <= fl_d;
         kind_q       <= kind_d;
         pause_sent_q <= pause_sent_d;
         flow_data_q  <= flow_data_d;
      end
   end

   // pin outputs idle high, transmit dma ready low
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sout_q     <= 1'b1;
         rts_n_q    <= 1'b1;
         dtr_n_q    <= 1'b1;
         rx_dma_n_q <= 1'b1;
         tx_dma_n_q <= 1'b0;
      end
      else
      begin
         sout_q     <= TX_BIT;
         rts_n_q    <= efr_q[EFR_AUTO_RTS] ? (rts_hold_q | ~mcr_q[MCR_RTS]) : ~mcr_q[MCR_RTS];
         dtr_n_q    <= ~mcr_q[MCR_DTR];
         rx_dma_n_q <= ~at_trig;
         tx_dma_n_q <= TX_BUSY;
      end
   end

   assign SOUT                   = sout_q;
   assign RTS_N                  = rts_n_q;
   assign DTR_N                  = dtr_n_q;
   assign RECEIVE_DMA_REQUEST_N  = rx_dma_n_q;
   assign TRANSMIT_DMA_REQUEST_N = tx_dma_n_q;
   assign RX_TRIGGER_IRQ         = isr_q[ISR_RX_TRIG];

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence s_both_first;
      fl_q == FL_FIRST && TX_FLOW_READY && tx_sel == SEL_BOTH;
   endsequence
   sequence s_pair_second;
      fl_q == FL_SECOND && TX_FLOW_VALID && TX_FLOW_DATA == (kind_q ? pause2_q : resume2_q);
   endsequence

   chk_cts_blocks_start: assert property (efr_q[EFR_AUTO_CTS] && pin_sync_q[0] |-> !TX_START)
      else $error("start granted while cts high");
   chk_start_when_idle: assert property (TX_START |-> TX_REQ && !TX_BUSY)
      else $error("start granted during a character");
   chk_rts_raise: assert property (efr_q[EFR_AUTO_RTS] && level >= hi_lvl |=> rts_hold_q ##1 RTS_N)
      else $error("auto rts did not raise");
   chk_rts_drop: assert property (efr_q[EFR_AUTO_RTS] && mcr_q[MCR_RTS] && level < lo_lvl
      ##1 efr_q[EFR_AUTO_RTS] && mcr_q[MCR_RTS] |=> !RTS_N)
      else $error("auto rts did not drop");
   chk_rts_manual: assert property (!efr_q[EFR_AUTO_RTS] |=> RTS_N == !$past(mcr_q[MCR_RTS]))
      else $error("rts not following modem control");
   chk_special_flag: assert property (special_hit |=> isr_q[ISR_SPECIAL] ##1 !isr_q[ISR_NONE])
      else $error("special character not flagged");
   chk_enh_lock: assert property (apb_wr && PADDR == OFS_IER && !enh
      |=> ier_q[7:4] == $past(ier_q[7:4]))
      else $error("enhanced bits changed while locked");
   chk_tx_select: assert property (fl_q == FL_IDLE && need_pause && tx_sel == SEL_SECOND
      |=> TX_FLOW_VALID && TX_FLOW_DATA == $past(pause2_q))
      else $error("wrong transmit flow character");
   chk_rx_first: assert property (RX_VALID && rx_sel == SEL_FIRST && m_p1 |=> remote_pause_q)
      else $error("pause not seen on first pair");
   chk_rx_sequence: assert property (RX_VALID && rx_sel == SEL_BOTH && prev_p1_q && m_p2 |=> remote_pause_q)
      else $error("pause sequence not seen");
   chk_pair_order: assert property (s_both_first |=> s_pair_second)
      else $error("second flow character missing");
   chk_remote_hold: assert property (remote_pause_q |-> !TX_START)
      else $error("start granted while paused");
endmodule : ueflow_top
